// ### verilog/wdc_top.sv
// Watchdog timer control: control register, timed access, counter and reset-cause handling.
// Assumes RESET is the power-on reset on CORE_CLK; other resets and pins arrive unsynchronised.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps

module wdc_top
  import wdc_pkg::*;
(
  // Clock and power-on reset.
  input wire logic CORE_CLK,
  input wire logic RESET,
  // Other reset causes and power state, from outside the clock domain.
  input wire logic OTHER_RESET,
  input wire logic SLEEP_MODE,
  input wire logic [3:0] CONFIG_WATCHDOG_ENABLE,
  // Avalon-MM slave.
  input wire logic [AVS_ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Reset request to the system on a watchdog time-out.
  output logic WDT_RESET_REQ
);

  typedef struct packed {
    logic [1:0] other_rst_sync;
    logic [1:0] sleep_sync;
    logic [7:0] cfg_sync;
    logic timer_run_control;
    logic clear_pending;
    logic timeout_flag;
    logic run_in_sleep_modes;
    logic watchdog_reset_flag;
    logic [2:0] clock_prescale_select;
    logic [WDT_COUNT_W-1:0] count;
    wdc_ta_state_t ta_state;
    logic [3:0] ta_timer;
    logic [31:0] readdata;
    logic waitrequest;
    logic reset_req;
  } wdc_state_t;

  wdc_state_t state;
  wdc_state_t next_state;
  logic tick;
  logic other_reset;
  logic sleeping;
  logic [3:0] config_watchdog_enable;
  logic timer_mode;
  logic count_enable;
  logic overflow;
  logic take;
  logic hit_ctrl;
  logic hit_ta;
  logic ctrl_write;
  logic [7:0] wbyte;
  logic [7:0] ctrl_value;

  wdc_prescaler u_prescaler (
    .clk(CORE_CLK),
    .reset(RESET),
    .select(state.clock_prescale_select),
    .tick(tick)
  );

  // Second stage of each synchroniser is the only one read by logic.
  assign other_reset = state.other_rst_sync[1];
  assign sleeping = state.sleep_sync[1];
  assign config_watchdog_enable = state.cfg_sync[7:4];

  always_comb begin
    timer_mode = (config_watchdog_enable == CFG_TIMER_MODE);
    // In timer mode software gates the counter; otherwise the watchdog always runs.
    if (timer_mode) begin
      count_enable = state.timer_run_control
        && (!sleeping || state.run_in_sleep_modes);
    end else begin
      count_enable = 1'b1;
    end
    overflow = tick && count_enable && !state.clear_pending && (&state.count);
  end

  always_comb begin
    take = (AVS_READ || AVS_WRITE) && state.waitrequest;
    hit_ctrl = (AVS_ADDRESS == WATCHDOG_CONTROL_ADDR);
    hit_ta = (AVS_ADDRESS == TIMED_ACCESS_ADDR);
    wbyte = AVS_WRITEDATA[7:0];
    ctrl_write = take && AVS_WRITE && hit_ctrl && AVS_BYTEENABLE[0]
      && (state.ta_state == TA_OPEN);
    ctrl_value = {state.timer_run_control, state.clear_pending, state.timeout_flag,
      state.run_in_sleep_modes, state.watchdog_reset_flag, state.clock_prescale_select};
  end

  always_comb begin
    next_state = state;
    next_state.other_rst_sync = {state.other_rst_sync[0], OTHER_RESET};
    next_state.sleep_sync = {state.sleep_sync[0], SLEEP_MODE};
    next_state.cfg_sync = {state.cfg_sync[3:0], CONFIG_WATCHDOG_ENABLE};
    next_state.reset_req = 1'b0;

    // Bus handshake: one wait cycle, then a single cycle with waitrequest low.
    next_state.waitrequest = 1'b1;
    if (take) begin
      next_state.waitrequest = 1'b0;
      next_state.readdata = '0;
      if (AVS_READ && hit_ctrl) begin
        next_state.readdata = {24'h000000, ctrl_value};
      end
    end

    // Timed access: two key writes open a short window for one protected write.
    if (state.ta_state == TA_OPEN) begin
      if (state.ta_timer == 4'h0) begin
        next_state.ta_state = TA_LOCKED;
      end else begin
        next_state.ta_timer = state.ta_timer - 4'h1;
      end
    end
    if (take && AVS_WRITE) begin
      if (hit_ta && AVS_BYTEENABLE[0]) begin
        case (state.ta_state)
          TA_LOCKED: begin
            if (wbyte == TA_KEY_FIRST) begin
              next_state.ta_state = TA_GOT_FIRST;
            end
          end
          TA_GOT_FIRST: begin
            if (wbyte == TA_KEY_SECOND) begin
              next_state.ta_state = TA_OPEN;
              next_state.ta_timer = TA_WINDOW_CYCLES;
            end else begin
              next_state.ta_state = TA_LOCKED;
            end
          end
          TA_OPEN: begin
            next_state.ta_state = TA_LOCKED;
          end
          default: begin
            next_state.ta_state = TA_LOCKED;
          end
        endcase
      end else begin
        // Any other write spends the unlock once it is taken, the protected write included.
        next_state.ta_state = TA_LOCKED;
      end
    end

    // Counter: a pending clear is carried out at the next prescaler tick.
    if (tick) begin
      if (state.clear_pending) begin
        next_state.count = '0;
        next_state.clear_pending = 1'b0;
      end else if (count_enable) begin
        next_state.count = state.count + 6'h01;
      end
    end

    if (ctrl_write) begin
      next_state.timer_run_control = wbyte[BIT_RUN];
      next_state.run_in_sleep_modes = wbyte[BIT_SLEEP_RUN];
      next_state.watchdog_reset_flag = wbyte[BIT_RESET_FLAG];
      next_state.clock_prescale_select = wbyte[PS_MSB:PS_LSB];
      if (wbyte[BIT_CLEAR]) begin
        next_state.clear_pending = 1'b1;
      end
      if (!wbyte[BIT_TIMEOUT]) begin
        next_state.timeout_flag = 1'b0;
      end
    end

    // In timer mode the overflow set wins over a software clear in the same cycle.
    if (overflow) begin
      next_state.timeout_flag = 1'b1;
    end

    // A time-out outside timer mode requests a reset, clears the upper nibble, sets the flag and keeps the prescale bits.
    if (overflow && !timer_mode) begin
      next_state.reset_req = 1'b1;
      next_state.timer_run_control = 1'b0;
      next_state.clear_pending = 1'b0;
      next_state.timeout_flag = 1'b0;
      next_state.run_in_sleep_modes = 1'b0;
      next_state.watchdog_reset_flag = 1'b1;
      next_state.count = '0;
      next_state.ta_state = TA_LOCKED;
    end

    // Other resets clear the upper nibble and keep the flag and prescale bits.
    if (other_reset) begin
      next_state.timer_run_control = 1'b0;
      next_state.clear_pending = 1'b0;
      next_state.timeout_flag = 1'b0;
      next_state.run_in_sleep_modes = 1'b0;
      next_state.watchdog_reset_flag = state.watchdog_reset_flag;
      next_state.clock_prescale_select = state.clock_prescale_select;
      next_state.count = '0;
      next_state.ta_state = TA_LOCKED;
      next_state.reset_req = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state <= '0;
      state.timer_run_control <= CTRL_POR_VALUE[BIT_RUN];
      state.clear_pending <= CTRL_POR_VALUE[BIT_CLEAR];
      state.timeout_flag <= CTRL_POR_VALUE[BIT_TIMEOUT];
      state.run_in_sleep_modes <= CTRL_POR_VALUE[BIT_SLEEP_RUN];
      state.watchdog_reset_flag <= 1'b0;
      state.clock_prescale_select <= PS_POR_VALUE;
      state.ta_state <= TA_LOCKED;
      state.waitrequest <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign AVS_READDATA = state.readdata;
  assign AVS_WAITREQUEST = state.waitrequest;
  assign WDT_RESET_REQ = state.reset_req;

endmodule

// ### inc/wdc_pkg.sv
// Constants, register layout and reset values of the watchdog timer control block.
// Assumes a single 25 MHz core clock and an Avalon-MM master that addresses bytes.
package wdc_pkg;

  localparam int AVS_ADDR_W = 10;
  // Printed offsets are register indices; the byte address is four times the index.
  localparam logic [7:0] WATCHDOG_CONTROL_IDX = 8'haa;
  localparam logic [7:0] TIMED_ACCESS_IDX = 8'hc7;
  localparam logic [AVS_ADDR_W-1:0] WATCHDOG_CONTROL_ADDR = {WATCHDOG_CONTROL_IDX, 2'h0};
  localparam logic [AVS_ADDR_W-1:0] TIMED_ACCESS_ADDR = {TIMED_ACCESS_IDX, 2'h0};

  // Timed-access unlock keys and how long the unlock stays open, in core cycles.
  localparam logic [7:0] TA_KEY_FIRST = 8'haa;
  localparam logic [7:0] TA_KEY_SECOND = 8'h55;
  localparam int TA_WINDOW_NS = 160;
  localparam int CORE_CLK_MHZ = 25;
  localparam int TA_WINDOW_CYCLES_INT = (TA_WINDOW_NS * CORE_CLK_MHZ) / 1000;
  localparam logic [3:0] TA_WINDOW_CYCLES = 4'(TA_WINDOW_CYCLES_INT);

  // Field positions in the control byte.
  localparam int BIT_RUN = 7;
  localparam int BIT_CLEAR = 6;
  localparam int BIT_TIMEOUT = 5;
  localparam int BIT_SLEEP_RUN = 4;
  localparam int BIT_RESET_FLAG = 3;
  localparam int PS_MSB = 2;
  localparam int PS_LSB = 0;

  localparam logic [7:0] CTRL_POR_VALUE = 8'h07;
  localparam logic [2:0] PS_POR_VALUE = 3'h7;
  localparam logic [3:0] CFG_TIMER_MODE = 4'hf;

  localparam int WDT_COUNT_W = 6;
  localparam int PS_COUNT_W = 8;

  // Divide ratio minus one, per prescale code.
  localparam logic [PS_COUNT_W-1:0] PS_DIV0 = 8'h00;
  localparam logic [PS_COUNT_W-1:0] PS_DIV1 = 8'h03;
  localparam logic [PS_COUNT_W-1:0] PS_DIV2 = 8'h07;
  localparam logic [PS_COUNT_W-1:0] PS_DIV3 = 8'h0f;
  localparam logic [PS_COUNT_W-1:0] PS_DIV4 = 8'h1f;
  localparam logic [PS_COUNT_W-1:0] PS_DIV5 = 8'h3f;
  localparam logic [PS_COUNT_W-1:0] PS_DIV6 = 8'h7f;
  localparam logic [PS_COUNT_W-1:0] PS_DIV7 = 8'hff;

  typedef enum logic [1:0] {
    TA_LOCKED,
    TA_GOT_FIRST,
    TA_OPEN
  } wdc_ta_state_t;

endpackage

// ### verilog/wdc_prescaler.sv
// Clock prescaler of the watchdog: one tick every N core cycles.
// Assumes the select input comes from logic on the same clock.
`timescale 1ns/10ps

module wdc_prescaler
  import wdc_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Ratio select and tick out.
  input wire logic [2:0] select,
  output logic tick
);

  typedef struct packed {
    logic [PS_COUNT_W-1:0] count;
    logic tick;
  } wdc_ps_state_t;

  wdc_ps_state_t state;
  wdc_ps_state_t next_state;
  logic [PS_COUNT_W-1:0] limit;

  always_comb begin
    case (select)
      3'h0: limit = PS_DIV0;
      3'h1: limit = PS_DIV1;
      3'h2: limit = PS_DIV2;
      3'h3: limit = PS_DIV3;
      3'h4: limit = PS_DIV4;
      3'h5: limit = PS_DIV5;
      3'h6: limit = PS_DIV6;
      default: limit = PS_DIV7;
    endcase
  end

  always_comb begin
    next_state = state;
    // A change of select to a smaller ratio must not leave the count beyond the limit.
    if (state.count >= limit) begin
      next_state.count = '0;
      next_state.tick = 1'b1;
    end else begin
      next_state.count = state.count + 8'h01;
      next_state.tick = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick = state.tick;

endmodule

// ### verification/wdc_checker_sva.sv
// Port checker of the watchdog timer control block.
// Assumes the single CORE_CLK domain with RESET as its power-on reset.
`timescale 1ns/10ps
module wdc_checker
  import wdc_pkg::*;
(
  // Clock and inputs.
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [3:0] CONFIG_WATCHDOG_ENABLE,
  input wire logic [AVS_ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  // Outputs.
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic WDT_RESET_REQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  logic [6:0] gap;
  // A time-out needs 64 ticks from a zero count, so two requests are at least 64 cycles apart.
  always_ff @(posedge CORE_CLK) begin
    if (RESET || WDT_RESET_REQ) begin
      gap <= 7'h00;
    end else if (gap != 7'h7f) begin
      gap <= gap + 7'h01;
    end
  end
  AST_ANSWER_NEXT: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("request not answered after one cycle");
  AST_ANSWER_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer longer than one cycle");
  AST_REQ_PULSE: assert property (WDT_RESET_REQ |=> !WDT_RESET_REQ)
    else $error("reset request longer than one cycle");
  AST_TIMER_NO_REQ: assert property ((CONFIG_WATCHDOG_ENABLE == CFG_TIMER_MODE) [*5] |-> !WDT_RESET_REQ)
    else $error("reset request in timer mode");
  AST_UPPER_ZERO: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_UNMAPPED_ZERO: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS != WATCHDOG_CONTROL_ADDR |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  AST_DATA_HOLD: assert property (AVS_WAITREQUEST && $past(AVS_WAITREQUEST) |-> $stable(AVS_READDATA))
    else $error("read data changed between answers");
  AST_REQ_GAP: assert property (WDT_RESET_REQ |-> gap >= 7'h3e)
    else $error("time-out sooner than 64 ticks");
endmodule

bind wdc_top wdc_checker wdc_checker_i (.CORE_CLK(CORE_CLK), .RESET(RESET),
  .CONFIG_WATCHDOG_ENABLE(CONFIG_WATCHDOG_ENABLE), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .WDT_RESET_REQ(WDT_RESET_REQ));

// ### verification/test_watchdog_timer_control.sv
// Self-checking bench of the watchdog timer control block.
// Drives the register bus, reset causes and mode pins directly.
`timescale 1ns/10ps
module test_watchdog_timer_control
  import wdc_pkg::*;
();
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic other_reset = 1'b0;
  logic sleep_mode = 1'b0;
  logic [3:0] cfg_en = 4'hf;
  logic [AVS_ADDR_W-1:0] addr = '0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic waitreq;
  logic wdt_req;
  logic [7:0] got;
  int err_total = 0;
  int check_count = 0;
  int n;
  int r;
  wdc_top wdc_top_i (.CORE_CLK(core_clk), .RESET(reset), .OTHER_RESET(other_reset),
    .SLEEP_MODE(sleep_mode), .CONFIG_WATCHDOG_ENABLE(cfg_en), .AVS_ADDRESS(addr),
    .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_BYTEENABLE(4'h1), .AVS_WRITEDATA(wdata),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .WDT_RESET_REQ(wdt_req));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task automatic report_and_stop();
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk);
  endtask
  // One request held until waitrequest is seen low, then released for a cycle.
  task automatic bus(input logic wr, input logic [AVS_ADDR_W-1:0] a, input logic [7:0] d);
    int k;
    k = 0;
    addr <= a;
    wdata <= {24'h0, d};
    wr_en <= wr;
    rd_en <= !wr;
    // Registered outputs are looked at mid-cycle, where they have settled.
    do begin
      @(negedge core_clk);
      k++;
    end while (waitreq !== 1'b0 && k < 20);
    if (waitreq !== 1'b0) begin
      err_total++;
      report_and_stop();
    end
    @(posedge core_clk);
    got = rdata[7:0];
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rdc(input logic [AVS_ADDR_W-1:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(e, got);
  endtask
  task automatic cw(input logic [7:0] d);
    bus(1'b1, TIMED_ACCESS_ADDR, TA_KEY_FIRST);
    bus(1'b1, TIMED_ACCESS_ADDR, TA_KEY_SECOND);
    bus(1'b1, WATCHDOG_CONTROL_ADDR, d);
  endtask
  initial begin
    #3000000;
    err_total++;
    report_and_stop();
  end
  initial begin
    cyc(3);
    reset <= 1'b0;
    cyc(1);
    rdc(WATCHDOG_CONTROL_ADDR, CTRL_POR_VALUE);
    rdc(10'h000, 8'h00);
    bus(1'b1, WATCHDOG_CONTROL_ADDR, 8'h80);
    rdc(WATCHDOG_CONTROL_ADDR, CTRL_POR_VALUE);
    // Each code must time out between 64 and 65 of its periods after the clearing write.
    for (int c = 0; c < 8; c++) begin
      r = (c == 0) ? 1 : 2 << c;
      cw({5'h18, c[2:0]});
      cyc(64 * r - 8);
      rdc(WATCHDOG_CONTROL_ADDR, {5'h10, c[2:0]});
      cyc(r + 24);
      rdc(WATCHDOG_CONTROL_ADDR, {5'h14, c[2:0]});
    end
    cw(8'hc0);
    cyc(40);
    cw(8'hc0);
    cyc(40);
    rdc(WATCHDOG_CONTROL_ADDR, 8'h80);
    cw(8'h00);
    cyc(100);
    rdc(WATCHDOG_CONTROL_ADDR, 8'h00);
    sleep_mode <= 1'b1;
    cw(8'hc0);
    cyc(100);
    rdc(WATCHDOG_CONTROL_ADDR, 8'h80);
    cw(8'hd0);
    cyc(100);
    rdc(WATCHDOG_CONTROL_ADDR, 8'hb0);
    sleep_mode <= 1'b0;
    cw(8'h00);
    cfg_en <= 4'h0;
    n = 0;
    while (wdt_req !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    chk(8'h01, {7'h0, wdt_req});
    cyc(1);
    rdc(WATCHDOG_CONTROL_ADDR, 8'h08);
    cfg_en <= 4'hf;
    cyc(6);
    cw(8'h8d);
    other_reset <= 1'b1;
    cyc(4);
    other_reset <= 1'b0;
    cyc(4);
    rdc(WATCHDOG_CONTROL_ADDR, 8'h0d);
    reset <= 1'b1;
    cyc(3);
    reset <= 1'b0;
    cyc(1);
    rdc(WATCHDOG_CONTROL_ADDR, CTRL_POR_VALUE);
    report_and_stop();
  end
endmodule
